// ===== tmr8_wave_timer.sv
// 8-bit timer counter with compare output and AXI4-Lite registers
// Operation
// (RULE_01) nonzero output mode drives pin from wave_out
// (RULE_02) direction bit still decides pin drive
// (RULE_03) override ignores waveform generation mode
// (RULE_04) wave_out keeps state while pin disabled
// (RULE_05) output mode zero leaves wave_out alone
// (RULE_06) new output mode acts next match; force
// (RULE_07) output mode never changes counting sequence
// (RULE_08) normal mode increments, wraps FF to 00
// (RULE_09) normal overflow flag set as count hits zero
// (RULE_10) clear-on-match clears count at compare value
// (RULE_11) unbuffered compare below count wraps first
// (RULE_12) clear-on-match mode 1 toggles on match
// (RULE_13) toggle period follows (1 + compare) ticks
// (RULE_14) clear-on-match overflow set on MAX to 00
// (RULE_15) fast PWM counts 0 to FF, then clears
// (RULE_16) fast PWM 2 clear/set, 3 set/clear
// (RULE_17) fast PWM overflow set at count maximum
// (RULE_18) fast PWM period is 256 timer ticks
// (RULE_19) compare zero spike, compare max constant
// (RULE_20) fast PWM mode 1 toggles, buffered compare
// (RULE_21) match flag one tick late, write-one clears
// (RULE_22) PWM compare buffered, else written directly
// (RULE_23) force updates output, no flag, no clear
// (RULE_24) reset selects normal mode, override off, low
module tmr8_wave_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic timerTick,
   input wire logic portData,
   input wire logic pinDirectionBit,
   output logic pinOut,
   output logic pinOutEn_n,
   output logic waveOut,
   output logic overflowFlag,
   output logic matchFlag,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // new wave_out level for a match under the given output mode
   function automatic logic matchAction(
      input tmr8_pkg::tmr8_outmode_e om,
      input logic cur
   );
      case (om)
         tmr8_pkg::OUT_TOGGLE: matchAction = ~cur;
         tmr8_pkg::OUT_CLEAR: matchAction = 1'b0;
         tmr8_pkg::OUT_SET: matchAction = 1'b1;
         default: matchAction = cur;
      endcase
   endfunction

   function automatic logic isPwm(input tmr8_pkg::tmr8_mode_e m);
      isPwm = (m == tmr8_pkg::MODE_FAST_PWM) || (m == tmr8_pkg::MODE_PHASE);
   endfunction

   tmr8_pkg::tmr8_ctrl_s ctrl_q;
   tmr8_pkg::tmr8_flags_s flags_q;
   logic [7:0] count_q;
   logic [7:0] cmpActive_q;
   logic [7:0] cmpBuffer_q;
   logic matchPend_q;
   logic blockMatch_q;
   logic wave_q;
   logic wave_d;
   logic pinOut_q;
   logic pinOutEn_n_q;

   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // bus decode
   logic wrFire;
   logic rdFire;
   logic wrCtrl;
   logic wrCount;
   logic wrCompare;
   logic wrFlags;
   logic wrMapped;
   logic lowLane;
   logic forceStrobe;

   // counter decode
   logic atMax;
   logic compareHit;
   logic pwmMode;
   logic [7:0] nextCount;

   assign lowLane = s_axi_wstrb[0];
   assign wrFire = s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
   assign rdFire = s_axi_arvalid && !arready_q && !rvalid_q;
   assign wrCtrl = wrFire && lowLane && (s_axi_awaddr == tmr8_pkg::ADDR_CTRL);
   assign wrCount = wrFire && lowLane
      && (s_axi_awaddr == tmr8_pkg::ADDR_COUNT);
   assign wrCompare = wrFire && lowLane
      && (s_axi_awaddr == tmr8_pkg::ADDR_COMPARE);
   assign wrFlags = wrFire && lowLane
      && (s_axi_awaddr == tmr8_pkg::ADDR_FLAGS);
   assign wrMapped = (s_axi_awaddr == tmr8_pkg::ADDR_CTRL)
      || (s_axi_awaddr == tmr8_pkg::ADDR_COUNT)
      || (s_axi_awaddr == tmr8_pkg::ADDR_COMPARE)
      || (s_axi_awaddr == tmr8_pkg::ADDR_FLAGS);

   // force acts with the output mode being written in the same access
   assign forceStrobe = wrCtrl && s_axi_wdata[tmr8_pkg::CTRL_FORCE_BIT]
      && !isPwm(tmr8_pkg::tmr8_mode_e'(
         s_axi_wdata[tmr8_pkg::CTRL_MODE_LO +: 2])); // [RULE_06]

   assign pwmMode = isPwm(ctrl_q.waveGenMode);
   assign atMax = (count_q == tmr8_pkg::COUNT_MAX);
   assign compareHit = (count_q == cmpActive_q) && !blockMatch_q;

   // next count, driven only by the generation mode [RULE_07]
   always_comb
   begin
      nextCount = count_q + tmr8_pkg::COUNT_ONE; // [RULE_08] [RULE_15]
      if ((ctrl_q.waveGenMode == tmr8_pkg::MODE_CLEAR_ON_MATCH) && compareHit)
      begin
         nextCount = tmr8_pkg::COUNT_BOTTOM; // [RULE_10] [RULE_11]
      end
   end

   // waveform output register next value
   always_comb
   begin
      wave_d = wave_q;
      if (timerTick)
      begin
         if (ctrl_q.waveGenMode == tmr8_pkg::MODE_FAST_PWM)
         begin
            if (compareHit)
            begin
               wave_d = matchAction(ctrl_q.compareOutputMode,
                  wave_q); // [RULE_16] [RULE_20]
            end
            // wrap action wins so compare at max gives a steady level
            if (atMax)
            begin
               case (ctrl_q.compareOutputMode)
                  tmr8_pkg::OUT_CLEAR: wave_d = 1'b1; // [RULE_16] [RULE_19]
                  tmr8_pkg::OUT_SET: wave_d = 1'b0; // [RULE_16] [RULE_19]
                  default: wave_d = wave_d;
               endcase
            end
         end
         else if (!pwmMode && compareHit)
         begin
            wave_d = matchAction(ctrl_q.compareOutputMode,
               wave_q); // [RULE_05] [RULE_12] [RULE_13]
         end
      end
      if (forceStrobe)
      begin
         wave_d = matchAction(tmr8_pkg::tmr8_outmode_e'(
            s_axi_wdata[tmr8_pkg::CTRL_OUTMODE_LO +: 2]),
            wave_q); // [RULE_23] [RULE_05]
      end
   end

   // control register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q <= tmr8_pkg::CTRL_RESET; // [RULE_24]
      end
      else if (wrCtrl)
      begin
         ctrl_q.waveGenMode <= tmr8_pkg::tmr8_mode_e'(
            s_axi_wdata[tmr8_pkg::CTRL_MODE_LO +: 2]);
         ctrl_q.compareOutputMode <= tmr8_pkg::tmr8_outmode_e'(
            s_axi_wdata[tmr8_pkg::CTRL_OUTMODE_LO +: 2]); // [RULE_06]
      end
   end

   // counter; a software write beats the tick and blocks one match
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_q <= tmr8_pkg::COUNT_BOTTOM;
         blockMatch_q <= 1'b0;
      end
      else if (wrCount)
      begin
         count_q <= s_axi_wdata[7:0];
         blockMatch_q <= 1'b1;
      end
      else if (timerTick)
      begin
         count_q <= nextCount; // [RULE_18]
         blockMatch_q <= 1'b0;
      end
   end

   // compare value and its buffer, copied at wrap in PWM modes
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmpBuffer_q <= tmr8_pkg::COUNT_BOTTOM;
         cmpActive_q <= tmr8_pkg::COUNT_BOTTOM;
      end
      else
      begin
         if (wrCompare)
         begin
            cmpBuffer_q <= s_axi_wdata[7:0];
         end
         if (wrCompare && !pwmMode)
         begin
            cmpActive_q <= s_axi_wdata[7:0]; // [RULE_22] [RULE_11]
         end
         else if (pwmMode && timerTick && atMax)
         begin
            cmpActive_q <= cmpBuffer_q; // [RULE_22] [RULE_20]
         end
      end
   end

   // waveform output register, kept regardless of pin state
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wave_q <= 1'b0; // [RULE_24]
      end
      else
      begin
         wave_q <= wave_d; // [RULE_04]
      end
   end

   // flags: hardware set wins over a write-one clear
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flags_q <= '0;
         matchPend_q <= 1'b0;
      end
      else
      begin
         if (timerTick)
         begin
            matchPend_q <= compareHit;
         end
         if (wrFlags && s_axi_wdata[tmr8_pkg::FLAG_OVF_BIT])
         begin
            flags_q.overflowFlag <= 1'b0;
         end
         if (wrFlags && s_axi_wdata[tmr8_pkg::FLAG_MATCH_BIT])
         begin
            flags_q.matchFlag <= 1'b0; // [RULE_21]
         end
         if (timerTick && atMax && (ctrl_q.waveGenMode != tmr8_pkg::MODE_PHASE))
         begin
            flags_q.overflowFlag <= 1'b1; // [RULE_09] [RULE_14] [RULE_17]
         end
         if (timerTick && matchPend_q)
         begin
            flags_q.matchFlag <= 1'b1; // [RULE_21]
         end
      end
   end

   // pin multiplexer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pinOut_q <= 1'b0;
         pinOutEn_n_q <= 1'b1;
      end
      else
      begin
         pinOut_q <= (ctrl_q.compareOutputMode != tmr8_pkg::OUT_OFF)
            ? wave_d : portData; // [RULE_01] [RULE_03]
         pinOutEn_n_q <= !pinDirectionBit; // [RULE_02]
      end
   end

   // AXI4-Lite write channel
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= tmr8_pkg::RESP_OKAY;
      end
      else
      begin
         awready_q <= wrFire;
         wready_q <= wrFire;
         if (wrFire)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= wrMapped ? tmr8_pkg::RESP_OKAY : tmr8_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= tmr8_pkg::DATA_ZERO;
         rresp_q <= tmr8_pkg::RESP_OKAY;
      end
      else
      begin
         arready_q <= rdFire;
         if (rdFire)
         begin
            rvalid_q <= 1'b1;
            rresp_q <= tmr8_pkg::RESP_OKAY;
            rdata_q <= tmr8_pkg::DATA_ZERO;
            case (s_axi_araddr)
               tmr8_pkg::ADDR_CTRL: rdata_q[3:0] <= ctrl_q;
               tmr8_pkg::ADDR_COUNT: rdata_q[7:0] <= count_q;
               tmr8_pkg::ADDR_COMPARE: rdata_q[7:0] <= cmpBuffer_q;
               tmr8_pkg::ADDR_FLAGS: rdata_q[1:0] <= flags_q;
               default: rresp_q <= tmr8_pkg::RESP_SLVERR;
            endcase
         end
         else if (s_axi_rready)
         begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign pinOut = pinOut_q;
   assign pinOutEn_n = pinOutEn_n_q;
   assign waveOut = wave_q;
   assign overflowFlag = flags_q.overflowFlag;
   assign matchFlag = flags_q.matchFlag;
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

endmodule // tmr8_wave_timer

// ===== tmr8_pkg.sv
// constants, types and register map of the 8-bit timer waveform block
package tmr8_pkg;

   // register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_COUNT = 8'h04;
   localparam logic [7:0] ADDR_COMPARE = 8'h08;
   localparam logic [7:0] ADDR_FLAGS = 8'h0C;
   localparam int ADDR_W = 8;

   // control register field positions
   localparam int CTRL_MODE_LO = 0;
   localparam int CTRL_OUTMODE_LO = 2;
   localparam int CTRL_FORCE_BIT = 7;
   // flag register field positions
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_MATCH_BIT = 1;

   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam logic [7:0] COUNT_ONE = 8'h01;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_PHASE = 2'h1,
      MODE_CLEAR_ON_MATCH = 2'h2,
      MODE_FAST_PWM = 2'h3
   } tmr8_mode_e;

   typedef enum logic [1:0] {
      OUT_OFF = 2'h0,
      OUT_TOGGLE = 2'h1,
      OUT_CLEAR = 2'h2,
      OUT_SET = 2'h3
   } tmr8_outmode_e;

   typedef struct packed {
      tmr8_outmode_e compareOutputMode;
      tmr8_mode_e waveGenMode;
   } tmr8_ctrl_s;

   localparam tmr8_ctrl_s CTRL_RESET = '{OUT_OFF, MODE_NORMAL};

   typedef struct packed {
      logic matchFlag;
      logic overflowFlag;
   } tmr8_flags_s;

endpackage : tmr8_pkg

// ===== tmr8_wave_timer_sva.sv
// port assertions for the timer waveform block
module tmr8_wave_timer_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic timerTick,
   input wire logic pinDirectionBit,
   input wire logic pinOut,
   input wire logic pinOutEn_n,
   input wire logic waveOut,
   input wire logic overflowFlag,
   input wire logic matchFlag,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_awready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] outModeQ;
   logic flagWr;
   // output mode as written, one cycle behind the block
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         outModeQ <= 2'h0;
      else if (s_axi_awready && s_axi_wstrb[0] &&
               s_axi_awaddr == tmr8_pkg::ADDR_CTRL)
         outModeQ <= s_axi_wdata[3:2];
   end
   assign flagWr = s_axi_awready && s_axi_wstrb[0] &&
                   s_axi_awaddr == tmr8_pkg::ADDR_FLAGS;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_PIN_DIR: assert property (
      $past(rst_n) |-> pinOutEn_n == !$past(pinDirectionBit))
      else $error("pin enable wrong");
   AST_PIN_WAVE: assert property (
      !s_axi_awready && $stable(outModeQ) && outModeQ != 2'h0
      |-> pinOut == waveOut) else $error("pin not from wave");
   AST_OVF_CLR: assert property (
      $fell(overflowFlag) |-> flagWr && s_axi_wdata[0])
      else $error("overflow lost");
   AST_MATCH_CLR: assert property (
      $fell(matchFlag) |-> flagWr && s_axi_wdata[1])
      else $error("match flag lost");
   AST_OVF_TICK: assert property (
      $rose(overflowFlag) |-> $past(timerTick))
      else $error("overflow off tick");
   AST_MATCH_TICK: assert property (
      $rose(matchFlag) |-> $past(timerTick))
      else $error("match flag off tick");
   AST_WAVE_HOLD: assert property (
      !s_axi_awready && outModeQ == 2'h0 && $past(outModeQ) == 2'h0
      |-> $stable(waveOut)) else $error("wave moved in mode 0");
   AST_WAVE_CAUSE: assert property (
      $changed(waveOut) |-> $past(timerTick) || s_axi_awready)
      else $error("wave moved without cause");
endmodule // tmr8_wave_timer_sva

bind tmr8_wave_timer tmr8_wave_timer_sva i_sva (.clk, .rst_n, .timerTick,
   .pinDirectionBit, .pinOut, .pinOutEn_n, .waveOut, .overflowFlag,
   .matchFlag, .s_axi_awaddr, .s_axi_wdata, .s_axi_wstrb, .s_axi_awready);

// ===== tmr8_pin_model.sv
// port pin model that resolves the pad level
module tmr8_pin_model (
   input wire logic clk,
   input wire logic pinOut,
   input wire logic pinOutEn_n,
   output logic pinLevel
);
   timeunit 1ns;
   timeprecision 1ns;
   logic lastQ = 1'b0;
   always_ff @(posedge clk)
   begin
      if (!pinOutEn_n)
         lastQ <= pinOut;
   end
   // released pad must not look like the last drive
   assign pinLevel = pinOutEn_n ? ~lastQ : pinOut;
endmodule // tmr8_pin_model

// ===== tb_tmr8_wave_timer.sv
// self-checking bench for the timer waveform block
module tb_tmr8_wave_timer;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, timerTick = 1'b0;
   logic portData = 1'b0, pinDirectionBit = 1'b0;
   logic pinOut, pinOutEn_n, waveOut, overflowFlag, matchFlag, pinLevel;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   int fails = 0;
   int num_checks = 0;

   tmr8_wave_timer i_dut (.clk, .rst_n, .timerTick, .portData,
      .pinDirectionBit, .pinOut, .pinOutEn_n, .waveOut, .overflowFlag,
      .matchFlag, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   tmr8_pin_model i_pin (.clk, .pinOut, .pinOutEn_n, .pinLevel);

   initial
      forever #50 clk = ~clk;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step(inout int n);
      @(posedge clk);
      n++;
      if (n > 40)
      begin
         fails++;
         report_and_stop();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
         step(n);
      while (!s_axi_awready);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      while (!s_axi_bvalid)
         step(n);
      s_axi_bready <= 1'b0;
      // idle edge so a following call never re-raises valid in this step
      @(posedge clk);
   endtask

   task automatic rdr(input logic [7:0] a);
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
         step(n);
      while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid)
         step(n);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      // idle edge so a following call never re-raises valid in this step
      @(posedge clk);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      rdr(a);
      chk(rd, exp);
   endtask

   task automatic tick(input int k);
      timerTick <= 1'b1;
      repeat (k) @(posedge clk);
      timerTick <= 1'b0;
      @(posedge clk);
   endtask

   task automatic sc_rst();
      chk(pinOutEn_n, 1'b1);
      chk(waveOut, 1'b0);
      rc(tmr8_pkg::ADDR_CTRL, 32'h0000_0000);
      rdr(8'h10);
      chk(rsp, tmr8_pkg::RESP_SLVERR);
   endtask

   task automatic sc_norm();
      wr(tmr8_pkg::ADDR_CTRL, 32'h0000_0004);
      wr(tmr8_pkg::ADDR_COUNT, 32'h0000_00FD);
      tick(2);
      rc(tmr8_pkg::ADDR_COUNT, 32'h0000_00FF);
      chk(overflowFlag, 1'b0);
      tick(1);
      chk(overflowFlag, 1'b1);
      rc(tmr8_pkg::ADDR_COUNT, 32'h0000_0000);
      wr(tmr8_pkg::ADDR_FLAGS, 32'h0000_0003);
      chk(overflowFlag, 1'b0);
   endtask

   task automatic sc_force();
      wr(tmr8_pkg::ADDR_CTRL, 32'h0000_008C);
      chk(waveOut, 1'b1);
      chk(pinOutEn_n, 1'b1);
      chk(matchFlag, 1'b0);
      rc(tmr8_pkg::ADDR_COUNT, 32'h0000_0000);
      pinDirectionBit <= 1'b1;
      repeat (2) @(posedge clk);
      chk(pinLevel, 1'b1);
      wr(tmr8_pkg::ADDR_CTRL, 32'h0000_0080);
      @(posedge clk);
      chk(waveOut, 1'b1);
      chk(pinLevel, 1'b0);
      rc(tmr8_pkg::ADDR_CTRL, 32'h0000_0000);
   endtask

   task automatic sc_ctc();
      wr(tmr8_pkg::ADDR_COMPARE, 32'h0000_0003);
      wr(tmr8_pkg::ADDR_COUNT, 32'h0000_0000);
      wr(tmr8_pkg::ADDR_CTRL, 32'h0000_0006);
      tick(3);
      rc(tmr8_pkg::ADDR_COUNT, 32'h0000_0003);
      tick(1);
      chk(waveOut, 1'b0);
      chk(matchFlag, 1'b0);
      rc(tmr8_pkg::ADDR_COUNT, 32'h0000_0000);
      tick(1);
      chk(matchFlag, 1'b1);
      tick(2);
      chk(waveOut, 1'b0);
      tick(1);
      chk(waveOut, 1'b1);
      wr(tmr8_pkg::ADDR_FLAGS, 32'h0000_0003);
      chk(matchFlag, 1'b0);
      tick(2);
      wr(tmr8_pkg::ADDR_COMPARE, 32'h0000_0001);
      tick(253);
      chk(overflowFlag, 1'b0);
      tick(1);
      chk(overflowFlag, 1'b1);
      rc(tmr8_pkg::ADDR_COUNT, 32'h0000_0000);
   endtask

   task automatic sc_pwm();
      wr(tmr8_pkg::ADDR_FLAGS, 32'h0000_0003);
      wr(tmr8_pkg::ADDR_CTRL, 32'h0000_000B);
      wr(tmr8_pkg::ADDR_COMPARE, 32'h0000_0040);
      wr(tmr8_pkg::ADDR_COUNT, 32'h0000_0000);
      tick(2);
      chk(waveOut, 1'b0);
      rc(tmr8_pkg::ADDR_COMPARE, 32'h0000_0040);
      tick(253);
      chk(overflowFlag, 1'b0);
      tick(1);
      chk(overflowFlag, 1'b1);
      chk(pinLevel, 1'b1);
      rc(tmr8_pkg::ADDR_COUNT, 32'h0000_0000);
      tick(64);
      chk(waveOut, 1'b1);
      tick(1);
      chk(waveOut, 1'b0);
      tick(190);
      chk(waveOut, 1'b0);
      tick(1);
      chk(waveOut, 1'b1);
      wr(tmr8_pkg::ADDR_CTRL, 32'h0000_000F);
      tick(255);
      chk(waveOut, 1'b1);
      tick(1);
      chk(waveOut, 1'b0);
   endtask

   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      sc_rst();
      sc_norm();
      sc_force();
      sc_ctc();
      sc_pwm();
      report_and_stop();
   end
endmodule // tb_tmr8_wave_timer
